// >>> hdl/crg_top.sv
// Contract
// RULE1: bus ratio codes 000..011 give x4, x2, x1, x1/2; codes 1xx are refused.
// RULE2: a bus ratio faster than the system clock runs at the system rate.
// RULE3: the core clock is fixed at four times the oscillator clock.
// RULE4: core phase boundaries track rising edges of the oscillator input.
// RULE5: dividers give half, quarter, eighth rates; each follows its changed field.
// RULE6: after a write, wait for bus cycle end, then switch within one input period.
// RULE7: system clock never slower than peripheral or bus clock; system setting wins.
// RULE8: all peripherals except the two transfer engines run on the peripheral clock.
// RULE9: software keeps every clock inside its guaranteed frequency range.
// RULE10: an external clock on the oscillator output pin stays high in standby. This block has no oscillator output pin and no standby input.
// RULE11: system ratio codes 000..011 give x4..x1/2 for cpu and engines; 1xx refused.
// RULE12: peripheral ratio codes 000..011 give x4..x1/2; codes 1xx are refused.
// RULE13: switching waits for clock boundaries so no shortened pulse is emitted.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "crg_cfg.svh"
module crg_top (
  input wire logic clk, // multiplied core clock, 40 MHz
  input wire logic reset, // sync reset, active high
  input wire logic osc_input_pin, // oscillator input pin level
  input wire logic bus_cycle_busy, // a bus cycle is in progress
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic sys_clk_en, // system clock tick: cpu and both transfer engines
  output logic periph_clk_en, // peripheral module clock tick
  output logic bus_clk_en // external bus clock tick
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // phase bits that must be zero for a tick at each divide code
  function automatic logic [2:0] ratio_mask(input crg_pkg::crg_ratio_type r);
    logic [2:0] m;
    m = 3'h0;
    case (r)
      crg_pkg::CRG_X4: m = 3'h0;
      crg_pkg::CRG_X2: m = 3'h1;
      crg_pkg::CRG_X1: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

  // a field takes a new code only when its lane is written and the code is allowed
  function automatic crg_pkg::crg_code_type field_upd(input crg_pkg::crg_code_type old_v,
      input crg_pkg::crg_code_type new_v, input logic lane);
    return (lane && !new_v[`CRG_PROHIB_BIT]) ? new_v : old_v;
  endfunction

  // the system setting caps the others: never faster than the system clock
  function automatic crg_pkg::crg_ratio_type cap(input crg_pkg::crg_ratio_type own,
      input crg_pkg::crg_ratio_type sys);
    return (own < sys) ? sys : own;
  endfunction

  // ----------------------------------------------------------------
  // bus slave and phase source
  // ----------------------------------------------------------------
  crg_reg_if rif ();

  crg_axil_slave u_slave (
    .clk(clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.slave)
  );

  logic [2:0] cnt, cnt_next;

  crg_phase_align u_phase (
    .clk(clk),
    .reset(reset),
    .osc_input_pin(osc_input_pin),
    .cnt(cnt),
    .cnt_next(cnt_next)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  crg_pkg::crg_code_type sys_sel_reg, per_sel_reg, bus_sel_reg;
  crg_pkg::crg_code_type sys_sel_next, per_sel_next, bus_sel_next;
  logic pending_reg, pending_next;

  wire wr_ctrl = rif.wr_fire && (rif.wr_addr == `CRG_ADDR_CTRL);
  wire wr_stat = rif.wr_fire && (rif.wr_addr == `CRG_ADDR_STAT);
  wire lane_sys = wr_ctrl && rif.wr_strb[`CRG_SYS_LANE];
  wire lane_low = wr_ctrl && rif.wr_strb[`CRG_LOW_LANE];
  wire [2:0] wr_sys = rif.wr_data[`CRG_SYS_LSB +: `CRG_CODE_W];
  wire [2:0] wr_per = rif.wr_data[`CRG_PER_LSB +: `CRG_CODE_W];
  wire [2:0] wr_bus = rif.wr_data[`CRG_BUS_LSB +: `CRG_CODE_W];

  assign sys_sel_next = field_upd(sys_sel_reg, wr_sys, lane_sys); // RULE11
  assign per_sel_next = field_upd(per_sel_reg, wr_per, lane_low); // RULE12
  assign bus_sel_next = field_upd(bus_sel_reg, wr_bus, lane_low); // RULE1
  assign rif.wr_err = !wr_ctrl && !wr_stat;

  // the new ratios wait for the bus cycle to end and then for an input-clock boundary;
  // a write in the same cycle as the switch keeps the request alive
  wire phase_edge = (cnt[1:0] == `CRG_PHASE_ZERO);
  wire apply = pending_reg && !bus_cycle_busy && phase_edge; // RULE6
  assign pending_next = wr_ctrl || (pending_reg && !apply); // RULE6

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_sel_reg <= crg_pkg::crg_code_type'(`CRG_CTRL_RESET >> `CRG_SYS_LSB);
      per_sel_reg <= crg_pkg::crg_code_type'(`CRG_CTRL_RESET >> `CRG_PER_LSB);
      bus_sel_reg <= crg_pkg::crg_code_type'(`CRG_CTRL_RESET >> `CRG_BUS_LSB);
      pending_reg <= 1'b0;
    end else begin
      sys_sel_reg <= sys_sel_next;
      per_sel_reg <= per_sel_next;
      bus_sel_reg <= bus_sel_next;
      pending_reg <= pending_next;
    end
  end

  // ----------------------------------------------------------------
  // active ratios
  // ----------------------------------------------------------------
  crg_pkg::crg_ratio_type act_reg [3];
  crg_pkg::crg_ratio_type req_act [3];
  logic [2:0] tick_reg;

  assign req_act[0] = crg_pkg::crg_ratio_type'(sys_sel_reg[1:0]);
  assign req_act[1] = cap(crg_pkg::crg_ratio_type'(per_sel_reg[1:0]), req_act[0]); // RULE7
  assign req_act[2] = cap(crg_pkg::crg_ratio_type'(bus_sel_reg[1:0]), req_act[0]); // RULE2

  // one tick generator per clock; a tick lands where the shared phase count is a multiple
  // of the period, so a ratio change at a common boundary never shortens a period
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      crg_pkg::crg_ratio_type act_next;
      assign act_next = apply ? req_act[gi] : act_reg[gi]; // RULE5 RULE13
      always_ff @(posedge clk) begin
        if (reset) begin
          act_reg[gi] <= crg_pkg::crg_ratio_type'(`CRG_RESET_ACT);
          tick_reg[gi] <= 1'b0;
        end else begin
          act_reg[gi] <= act_next;
          tick_reg[gi] <= (cnt_next & ratio_mask(act_next)) == `CRG_CNT_ZERO; // RULE5
        end
      end
    end
  endgenerate

  assign sys_clk_en = tick_reg[0];
  assign periph_clk_en = tick_reg[1]; // RULE8
  assign bus_clk_en = tick_reg[2];

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire rd_ctrl = (rif.rd_addr == `CRG_ADDR_CTRL);
  wire rd_stat = (rif.rd_addr == `CRG_ADDR_STAT);
  wire [31:0] ctrl_word = {16'h0000, 5'h00, sys_sel_reg, 1'b0, per_sel_reg, 1'b0, bus_sel_reg};
  wire [31:0] stat_word = {16'h0000, pending_reg, 5'h00, act_reg[0], 2'h0,
    act_reg[1], 2'h0, act_reg[2]};

  assign rif.rd_data = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);
  assign rif.rd_err = !rd_ctrl && !rd_stat;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_bus_cap;
    @(posedge clk) disable iff (reset)
    act_reg[2] >= act_reg[0];
  endproperty
  a_bus_cap: assert property (p_bus_cap) else $error("bus clock faster than system clock"); // RULE2

  property p_per_cap;
    @(posedge clk) disable iff (reset)
    act_reg[1] >= act_reg[0];
  endproperty
  a_per_cap: assert property (p_per_cap) else $error("peripheral clock faster than system clock"); // RULE7

  property p_bus_refuse;
    @(posedge clk) disable iff (reset)
    lane_low && wr_bus[`CRG_PROHIB_BIT] |=> bus_sel_reg == $past(bus_sel_reg);
  endproperty
  a_bus_refuse: assert property (p_bus_refuse) else $error("prohibited bus code taken"); // RULE1

  property p_sys_refuse;
    @(posedge clk) disable iff (reset)
    lane_sys && wr_sys[`CRG_PROHIB_BIT] |=> sys_sel_reg == $past(sys_sel_reg);
  endproperty
  a_sys_refuse: assert property (p_sys_refuse) else $error("prohibited system code taken"); // RULE11

  property p_per_refuse;
    @(posedge clk) disable iff (reset)
    lane_low && wr_per[`CRG_PROHIB_BIT] |=> per_sel_reg == $past(per_sel_reg);
  endproperty
  a_per_refuse: assert property (p_per_refuse) else $error("prohibited peripheral code taken"); // RULE12

  property p_hold_busy;
    @(posedge clk) disable iff (reset)
    bus_cycle_busy |=> $stable(act_reg[0]) && $stable(act_reg[1]) && $stable(act_reg[2]);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("ratio changed during bus cycle"); // RULE6

  sequence s_idle_wait;
    (pending_reg && !bus_cycle_busy && !wr_ctrl)[*4];
  endsequence
  property p_switch_soon;
    @(posedge clk) disable iff (reset)
    s_idle_wait |=> !pending_reg;
  endproperty
  a_switch_soon: assert property (p_switch_soon) else $error("switch later than one input period"); // RULE6

  property p_follow;
    @(posedge clk) disable iff (reset)
    apply |=> act_reg[0] == $past(req_act[0]) && act_reg[2] == $past(req_act[2]);
  endproperty
  a_follow: assert property (p_follow) else $error("clock did not follow its field"); // RULE5

  sequence s_x1_tick;
    sys_clk_en && act_reg[0] == crg_pkg::CRG_X1 && !pending_reg;
  endsequence
  property p_no_short;
    @(posedge clk) disable iff (reset)
    s_x1_tick |=> !sys_clk_en[*3];
  endproperty
  a_no_short: assert property (p_no_short) else $error("shortened system clock period"); // RULE13

  property p_per_follow;
    @(posedge clk) disable iff (reset)
    apply |=> act_reg[1] == $past(req_act[1]);
  endproperty
  a_per_follow: assert property (p_per_follow) else $error("peripheral clock did not follow"); // RULE7

  property p_x4_every;
    @(posedge clk) disable iff (reset)
    act_reg[0] == crg_pkg::CRG_X4 |-> sys_clk_en;
  endproperty
  a_x4_every: assert property (p_x4_every) else $error("system tick missing at full rate"); // RULE11

  property p_per_tick_cap;
    @(posedge clk) disable iff (reset)
    periph_clk_en |-> sys_clk_en;
  endproperty
  a_per_tick_cap: assert property (p_per_tick_cap) else $error("peripheral tick without system tick"); // RULE7

  property p_bus_tick_cap;
    @(posedge clk) disable iff (reset)
    bus_clk_en |-> sys_clk_en;
  endproperty
  a_bus_tick_cap: assert property (p_bus_tick_cap) else $error("bus tick without system tick"); // RULE2

  property p_pend_set;
    @(posedge clk) disable iff (reset)
    wr_ctrl |=> pending_reg;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("control write did not arm the switch"); // RULE6

  property p_idle_hold;
    @(posedge clk) disable iff (reset)
    !pending_reg |=> $stable(act_reg[0]) && $stable(act_reg[1]) && $stable(act_reg[2]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("ratio changed with no pending write"); // RULE6

  property p_sys_keep;
    @(posedge clk) disable iff (reset)
    !lane_sys |=> sys_sel_reg == $past(sys_sel_reg);
  endproperty
  a_sys_keep: assert property (p_sys_keep) else $error("system field changed without a write"); // RULE11

  property p_per_take;
    @(posedge clk) disable iff (reset)
    lane_low && !wr_per[`CRG_PROHIB_BIT] |=> per_sel_reg == $past(wr_per);
  endproperty
  a_per_take: assert property (p_per_take) else $error("allowed peripheral code not stored"); // RULE12
endmodule
`default_nettype wire

// >>> hdl/crg_cfg.svh
`ifndef CRG_CFG_SVH
`define CRG_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CRG_ADDR_CTRL 32'h00000000
`define CRG_ADDR_STAT 32'h00000004
`define CRG_CTRL_RESET 16'h0222
`define CRG_CTRL_W 16
`define CRG_SYS_LSB 8
`define CRG_PER_LSB 4
`define CRG_BUS_LSB 0
`define CRG_CODE_W 3
`define CRG_PROHIB_BIT 2
`define CRG_SYS_LANE 1
`define CRG_LOW_LANE 0
`define CRG_STAT_PEND_BIT 15
`define CRG_RESET_ACT 2'h2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define CRG_RESP_OKAY 2'h0
`define CRG_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// divider and phase alignment
// ----------------------------------------------------------------
`define CRG_CNT_W 3
`define CRG_PHASE_W 2
`define CRG_PHASE_ZERO 2'h0
`define CRG_ALIGN_PHASE 2'h2
`define CRG_CNT_ONE 3'h1
`define CRG_CNT_ZERO 3'h0

`endif

// >>> hdl/crg_pkg.sv
package crg_pkg;
  // divide codes of the active clocks: larger code, slower clock
  typedef enum logic [1:0] {
    CRG_X4 = 2'b00,
    CRG_X2 = 2'b01,
    CRG_X1 = 2'b10,
    CRG_XHALF = 2'b11
  } crg_ratio_type;

  typedef enum logic [0:0] {
    CRG_W_IDLE = 1'b0,
    CRG_W_RESP = 1'b1
  } crg_wstate_type;

  typedef logic [2:0] crg_code_type;
endpackage

// >>> hdl/crg_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crg_reg_if;
  logic wr_fire;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slave (output wr_fire, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
  modport regs (input wr_fire, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// >>> hdl/crg_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "crg_cfg.svh"
module crg_axil_slave (
  input wire logic clk, // core clock
  input wire logic reset, // sync reset, active high
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  crg_reg_if.slave rif // register side
);
  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  crg_pkg::crg_wstate_type wst_reg, wst_next;
  logic aw_got_reg, w_got_reg;
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire both_got = aw_got_reg && w_got_reg;
  wire b_hs = s_axi_bvalid && s_axi_bready;

  assign rif.wr_fire = (wst_reg == crg_pkg::CRG_W_IDLE) && both_got;
  assign rif.wr_addr = awaddr_reg;
  assign rif.wr_data = wdata_reg;
  assign rif.wr_strb = wstrb_reg;
  assign s_axi_awready = !aw_got_reg && (wst_reg == crg_pkg::CRG_W_IDLE);
  assign s_axi_wready = !w_got_reg && (wst_reg == crg_pkg::CRG_W_IDLE);
  assign s_axi_bvalid = (wst_reg == crg_pkg::CRG_W_RESP);

  always_comb begin
    wst_next = wst_reg;
    case (wst_reg)
      crg_pkg::CRG_W_IDLE: begin
        if (both_got) begin
          wst_next = crg_pkg::CRG_W_RESP;
        end
      end
      crg_pkg::CRG_W_RESP: begin
        if (b_hs) begin
          wst_next = crg_pkg::CRG_W_IDLE;
        end
      end
      default: wst_next = crg_pkg::CRG_W_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wst_reg <= crg_pkg::CRG_W_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bresp <= `CRG_RESP_OKAY;
    end else begin
      wst_reg <= wst_next;
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (rif.wr_fire) begin
        aw_got_reg <= 1'b0;
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (rif.wr_fire) begin
        w_got_reg <= 1'b0;
      end
      if (rif.wr_fire) begin
        s_axi_bresp <= rif.wr_err ? `CRG_RESP_SLVERR : `CRG_RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign rif.rd_addr = s_axi_araddr;
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CRG_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rif.rd_data;
      s_axi_rresp <= rif.rd_err ? `CRG_RESP_SLVERR : `CRG_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_bvalid_hold;
    @(posedge clk) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped before bready");
endmodule
`default_nettype wire

// >>> hdl/crg_phase_align.sv
`timescale 1ns/1ps
`default_nettype none
`include "crg_cfg.svh"
module crg_phase_align (
  input wire logic clk, // multiplied clock
  input wire logic reset, // sync reset, active high
  input wire logic osc_input_pin, // oscillator input level
  output logic [2:0] cnt, // divider phase count
  output logic [2:0] cnt_next // next divider phase count
);
  // ----------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------
  logic sync1_reg, sync2_reg, sync3_reg;
  logic [2:0] cnt_reg;
  wire osc_rise = sync2_reg && !sync3_reg;
  wire [2:0] cnt_inc = cnt_reg + `CRG_CNT_ONE;

  // the low bits wrap every four core cycles: the core runs at four times the input clock
  // a pin rise forces the phase so boundaries track the input edge, less sync latency
  assign cnt_next = osc_rise ? {cnt_inc[2], `CRG_ALIGN_PHASE} : cnt_inc; // RULE3 RULE4
  assign cnt = cnt_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      cnt_reg <= `CRG_CNT_ZERO;
    end else begin
      sync1_reg <= osc_input_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cnt_reg <= cnt_next;
    end
  end

  property p_align;
    @(posedge clk) disable iff (reset)
    osc_rise |=> cnt_reg[1:0] == `CRG_ALIGN_PHASE;
  endproperty
  a_align: assert property (p_align) else $error("phase not aligned to input edge"); // RULE4

  property p_mult4;
    @(posedge clk) disable iff (reset)
    (cnt_reg[1:0] == `CRG_PHASE_ZERO && !osc_rise) ##1 (!osc_rise)[*3] |=> cnt_reg[1:0] == `CRG_PHASE_ZERO;
  endproperty
  a_mult4: assert property (p_mult4) else $error("input phase period not four cycles"); // RULE3
endmodule
`default_nettype wire

// >>> verification/test_clock_ratio_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "crg_cfg.svh"
module test_clock_ratio_generator;
  logic clk, reset, osc_input_pin, bus_cycle_busy;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sys_clk_en, periph_clk_en, bus_clk_en;
  logic [1:0] osc_cnt;
  logic [34:0] exp_q[$];
  logic [34:0] note;
  int failures, n_tests, seed;

  crg_top dut (.clk(clk), .reset(reset), .osc_input_pin(osc_input_pin), .bus_cycle_busy(bus_cycle_busy),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sys_clk_en(sys_clk_en),
    .periph_clk_en(periph_clk_en), .bus_clk_en(bus_clk_en));

  // ----------------------------------------------------------------
  // clock, oscillator input, checking
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // oscillator input at a quarter of the core rate, rising with a core edge
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    osc_input_pin <= osc_cnt[1];
  end

  task check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // oldest note is matched against each bus answer as it is taken
  always @(posedge clk) begin
    if ((s_axi_bvalid === 1'b1 && s_axi_bready) || (s_axi_rvalid === 1'b1 && s_axi_rready)) begin
      if (exp_q.size() == 0) begin
        failures++;
      end else begin
        note = exp_q.pop_front();
        if (s_axi_bvalid === 1'b1) check({s_axi_bresp, 32'h0}, note[33:0]);
        else check({s_axi_rresp, s_axi_rdata}, note[33:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // bus master and measurement tasks
  // ----------------------------------------------------------------
  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] resp);
    exp_q.push_back({1'b1, resp, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [31:0] a, input logic [33:0] e);
    exp_q.push_back({1'b1, e});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
  endtask

  // the interval right after a switch may be transitional, so the third tick is timed
  task period(input int sel, input logic [1:0] code);
    int n, k;
    logic tk;
    n = 0;
    k = 0;
    for (int i = 0; i < 40 && k < 3; i++) begin
      @(posedge clk);
      tk = (sel == 0) ? sys_clk_en : (sel == 1) ? periph_clk_en : bus_clk_en;
      if (k == 2) n++;
      if (tk === 1'b1) k++;
    end
    check({2'h0, 32'(n)}, {2'h0, 32'(1 << code)});
  endtask

  function automatic logic [31:0] ctrl_val(input logic [2:0] s, input logic [2:0] p, input logic [2:0] b);
    return {21'h0, s, 1'b0, p, 1'b0, b};
  endfunction

  function automatic logic [31:0] stat_val(input logic [1:0] s, input logic [1:0] p, input logic [1:0] b,
      input logic pend);
    return {16'h0, pend, 5'h0, s, 2'h0, p, 2'h0, b};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] sys, per, bus, pa, ba;
    seed = 28920;
    failures = 0;
    n_tests = 0;
    osc_cnt = 2'h0;
    osc_input_pin = 1'b0;
    bus_cycle_busy = 1'b0;
    reset = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    axi_rd(`CRG_ADDR_CTRL, {`CRG_RESP_OKAY, 32'h00000222});
    axi_rd(`CRG_ADDR_STAT, {`CRG_RESP_OKAY, stat_val(2'h2, 2'h2, 2'h2, 1'b0)});
    for (int i = 0; i < 16; i++) begin
      sys = 2'(i);
      bus = 2'(i >> 2);
      per = 2'($random(seed));
      axi_wr(`CRG_ADDR_CTRL, ctrl_val({1'b0, sys}, {1'b0, per}, {1'b0, bus}), 4'h3, `CRG_RESP_OKAY);
      repeat (5) @(posedge clk);
      pa = (per > sys) ? per : sys;
      ba = (bus > sys) ? bus : sys;
      axi_rd(`CRG_ADDR_CTRL, {`CRG_RESP_OKAY, ctrl_val({1'b0, sys}, {1'b0, per}, {1'b0, bus})});
      axi_rd(`CRG_ADDR_STAT, {`CRG_RESP_OKAY, stat_val(sys, pa, ba, 1'b0)});
      period(0, sys);
      period(1, pa);
      period(2, ba);
    end
    // prohibited codes leave every field as it was
    axi_wr(`CRG_ADDR_CTRL, 32'h00000444, 4'h3, `CRG_RESP_OKAY);
    axi_rd(`CRG_ADDR_CTRL, {`CRG_RESP_OKAY, ctrl_val(3'h3, {1'b0, per}, 3'h3)});
    axi_wr(`CRG_ADDR_CTRL, 32'h00000000, 4'h1, `CRG_RESP_OKAY);
    axi_rd(`CRG_ADDR_CTRL, {`CRG_RESP_OKAY, ctrl_val(3'h3, 3'h0, 3'h0)});
    // a busy bus holds the switch back
    bus_cycle_busy <= 1'b1;
    axi_wr(`CRG_ADDR_CTRL, 32'h00000000, 4'h2, `CRG_RESP_OKAY);
    repeat (20) @(posedge clk);
    axi_rd(`CRG_ADDR_STAT, {`CRG_RESP_OKAY, stat_val(2'h3, 2'h3, 2'h3, 1'b1)});
    bus_cycle_busy <= 1'b0;
    repeat (5) @(posedge clk);
    axi_rd(`CRG_ADDR_STAT, {`CRG_RESP_OKAY, stat_val(2'h0, 2'h0, 2'h0, 1'b0)});
    period(0, 2'h0);
    axi_wr(32'h00000008, 32'h00000333, 4'hf, `CRG_RESP_SLVERR);
    axi_rd(32'h00000008, {`CRG_RESP_SLVERR, 32'h0});
    axi_wr(`CRG_ADDR_STAT, 32'h00000333, 4'hf, `CRG_RESP_OKAY);
    axi_rd(`CRG_ADDR_CTRL, {`CRG_RESP_OKAY, 32'h0});
    finish_test;
  end

  initial begin
    #200000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
